/* File: logic/adccal_pkg.sv */
// Shared constants and types for the calibration control register block
package adccal_pkg;
   // ==========================================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_RUN  = 8'h61;
   localparam logic [7:0] IDX_MODE = 8'h62;
   localparam logic [7:0] IDX_OREF = 8'h65;
   localparam logic [7:0] IDX_AVG  = 8'h68;
   localparam logic [7:0] IDX_PROG = 8'h6a;
   localparam logic [7:0] IDX_PIN  = 8'h6b;
   localparam logic [7:0] IDX_SWT  = 8'h6c;
   localparam logic [7:0] IDX_IRQS = 8'h70;
   localparam logic [7:0] IDX_IRQM = 8'h71;
   // ==========================================================================
   // Reset values
   localparam logic [7:0] RST_RUN  = 8'h01;
   localparam logic [7:0] RST_MODE = 8'h01;
   localparam logic [7:0] RST_OREF = 8'h01;
   localparam logic [7:0] RST_AVG  = 8'h61;
   localparam logic [7:0] RST_PIN  = 8'h00;
   localparam logic [7:0] RST_SWT  = 8'h01;
   localparam logic [1:0] RST_IRQ  = 2'h0;
   // ==========================================================================
   // Field positions
   localparam int B_RUN   = 0;
   localparam int B_FGSEL = 0;
   localparam int B_BGEN  = 1;
   localparam int B_FGOS  = 2;
   localparam int B_BGOS  = 3;
   localparam int B_OREF  = 2;
   localparam int B_LAVG  = 0;
   localparam int B_OAVG  = 4;
   localparam int B_TSRC  = 0;
   localparam int B_PSEL  = 1;
   localparam int B_SWT   = 0;
   localparam int B_FGDN  = 0;
   localparam int B_STOP  = 1;
   localparam int B_CODE  = 2;
   localparam int IRQ_FG  = 0;
   localparam int IRQ_STP = 1;
   // ==========================================================================
   // Timing: base phase length in cycles, shifted left by the averaging code
   localparam int LIN_BASE_CYC = 16;
   localparam int OS_BASE_CYC  = 8;
   // ==========================================================================
   // Status pin select codes
   localparam logic [1:0] PSEL_FG  = 2'h0;
   localparam logic [1:0] PSEL_STP = 2'h1;
   localparam logic [1:0] PSEL_ALM = 2'h2;
   // ==========================================================================
   // Sequencer states and their reported status codes
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_FG_OS  = 6'b000010,
      ST_FG_LIN = 6'b000100,
      ST_BG_RUN = 6'b001000,
      ST_BG_STP = 6'b010000,
      ST_DONE   = 6'b100000
   } adccal_state_t;
   localparam logic [2:0] CODE_IDLE = 3'h0;
   localparam logic [2:0] CODE_FGOS = 3'h1;
   localparam logic [2:0] CODE_FGLN = 3'h2;
   localparam logic [2:0] CODE_BGRN = 3'h3;
   localparam logic [2:0] CODE_BGST = 3'h4;
   localparam logic [2:0] CODE_DONE = 3'h5;
endpackage

/* File: logic/adccal_regs.sv */
// Calibration control registers, sequencer, trigger select and status pin
`timescale 1ns/100ps

//Function
// RL1 - Background offset phase runs only with its enable and background enabled.
// RL2 - Foreground offset phase runs only with its enable and foreground selected.
// RL3 - Background enable turns background calibration on or off; off after reset.
// RL4 - Foreground select clear: reset values, skip. Set: reset values, run foreground.
// RL5 - Offset reference select zero targets mid-code; input must carry no offset.
// RL6 - Reference select one matches spare converter; software uses it only with background.
// RL7 - Offset averaging field bits 6:4, reset 6, longer averaging for larger codes.
// RL8 - Linearity averaging field bits 2:0, reset 1, longer averaging for larger codes.
// RL9 - Stopped flag reads one when background halts at a phase, zero on resume.
// RL10 - Without background calibration, stopped sets when foreground finishes or skips.
// RL11 - Foreground complete flag at bit 0; three-bit status code at bits 4:2.
// RL12 - Status pin select: complete flag, stopped flag, alarm, or constant low.
// RL13 - Trigger source zero uses the software bit and ignores the pin.
// RL14 - Trigger source one uses the pin and ignores the software bit.
// RL15 - Software writes reserved fields only with their reset defaults.
// RL16 - Software clears the run bit before changing settings, then sets it again.
// RL17 - Software trigger bit resets to one.
// RL18 - Status register writes are ignored; reads do not clear flags.
module adccal_regs #(
   parameter int LIN_BASE = adccal_pkg::LIN_BASE_CYC,
   parameter int OS_BASE  = adccal_pkg::OS_BASE_CYC
) (
   input  wire logic        ref_clk,              // 125 MHz clock
   input  wire logic        srst,                 // Synchronous reset, active high
   input  wire logic [9:0]  avs_address,          // Byte address
   input  wire logic        avs_read,             // Read request
   input  wire logic        avs_write,            // Write request
   input  wire logic [31:0] avs_writedata,        // Write data
   input  wire logic [3:0]  avs_byteenable,       // Byte enables
   output logic [31:0]      avs_readdata,         // Read data
   output logic             avs_waitrequest,      // Stall request
   input  wire logic        hardware_trigger_pin, // Asynchronous trigger pin
   input  wire logic        alarm_pin,            // Asynchronous alarm summary
   output logic             status_output_pin,    // Selected status
   output logic             irq,                  // Level interrupt
   output logic             cal_trigger,          // Selected calibration trigger
   output logic             cal_values_reset,     // One-cycle pulse at run start
   output logic             fg_offset_active,     // Foreground offset phase
   output logic             lin_cal_active,       // Linearity phase
   output logic             bg_offset_active,     // Background offset phase
   output logic             offset_ref_spare,     // Offset reference from spare
   output logic [2:0]       offset_averaging_depth,   // Offset averaging code
   output logic [2:0]       linearity_averaging_depth // Linearity averaging code
);
   import adccal_pkg::*;

   // Longest phase is the base shifted by seven; it must fit the 12-bit counter
   if (LIN_BASE < 1 || LIN_BASE * 128 > 4095 || OS_BASE < 1 || OS_BASE * 128 > 4095) begin : g_base_chk
      $error("adccal_regs: base phase length out of range");
   end

   typedef struct packed {
      logic [7:0]    run;
      logic [7:0]    mode;
      logic [7:0]    oref;
      logic [7:0]    avg;
      logic [7:0]    pin;
      logic [7:0]    swt;
      logic [1:0]    irqs;
      logic [1:0]    irqm;
      adccal_state_t st;
      logic [11:0]   cnt;
      logic          foreground_complete_flag;
      logic          stopped;
      logic          bg_os;
      logic          vrst;
      logic          ack;
      logic [31:0]   rdata;
      logic [2:0]    trg_s;
      logic          trg_q;
      logic [2:0]    alm_s;
      logic          alm_q;
      logic          spin;
      logic          trig;
   } adccal_reg_t;

   adccal_reg_t s_r;
   adccal_reg_t s_nxt;

   function automatic logic [11:0] phase_len(input int base, input logic [2:0] code);
      logic [11:0] b;
      b = base[11:0];
      return (b << code) - 12'h001;
   endfunction

   logic [7:0] idx;
   logic       wr_go;
   logic       rd_go;
   logic [2:0] code;
   logic       stp_rise;
   logic       fg_rise;

   assign idx   = avs_address[9:2];
   assign wr_go = avs_write & s_r.ack & avs_byteenable[0];
   assign rd_go = avs_read & ~s_r.ack;

   always_comb begin
      case (s_r.st)
         ST_FG_OS:  code = CODE_FGOS;
         ST_FG_LIN: code = CODE_FGLN;
         ST_BG_RUN: code = CODE_BGRN;
         ST_BG_STP: code = CODE_BGST;
         ST_DONE:   code = CODE_DONE;
         default:   code = CODE_IDLE;
      endcase
   end

   // ==========================================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.vrst = 1'b0;
      // Bus: one wait cycle; read data are latched while waitrequest is high
      s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
      if (rd_go) begin
         s_nxt.rdata = 32'h0;
         case (idx)
            IDX_RUN:  s_nxt.rdata[7:0] = s_r.run;
            IDX_MODE: s_nxt.rdata[7:0] = s_r.mode;
            IDX_OREF: s_nxt.rdata[7:0] = s_r.oref;
            IDX_AVG:  s_nxt.rdata[7:0] = s_r.avg;
            IDX_PROG: s_nxt.rdata[7:0] = {3'h0, code, s_r.stopped, s_r.foreground_complete_flag}; // see RL11 see RL18
            IDX_PIN:  s_nxt.rdata[7:0] = s_r.pin;
            IDX_SWT:  s_nxt.rdata[7:0] = s_r.swt;
            IDX_IRQS: s_nxt.rdata[7:0] = {6'h0, s_r.irqs};
            IDX_IRQM: s_nxt.rdata[7:0] = {6'h0, s_r.irqm};
            default:  s_nxt.rdata = 32'h0;
         endcase
      end
      // Progress register has no write case here, so writes to it fall away
      if (wr_go) begin
         case (idx)
            IDX_RUN:  s_nxt.run  = avs_writedata[7:0];
            IDX_MODE: s_nxt.mode = avs_writedata[7:0];
            IDX_OREF: s_nxt.oref = avs_writedata[7:0];
            IDX_AVG:  s_nxt.avg  = avs_writedata[7:0];
            IDX_PIN:  s_nxt.pin  = avs_writedata[7:0];
            IDX_SWT:  s_nxt.swt  = avs_writedata[7:0];
            IDX_IRQM: s_nxt.irqm = avs_writedata[1:0];
            default:  s_nxt.irqm = s_r.irqm; // see RL18
         endcase
      end

      // Pin inputs: a change counts once the last two stages agree
      s_nxt.trg_s = {s_r.trg_s[1:0], hardware_trigger_pin};
      if (s_r.trg_s[1] == s_r.trg_s[2]) begin
         s_nxt.trg_q = s_r.trg_s[2];
      end
      s_nxt.alm_s = {s_r.alm_s[1:0], alarm_pin};
      if (s_r.alm_s[1] == s_r.alm_s[2]) begin
         s_nxt.alm_q = s_r.alm_s[2];
      end

      // Trigger source
      if (s_r.pin[B_TSRC]) begin
         s_nxt.trig = s_r.trg_q; // see RL14
      end else begin
         s_nxt.trig = s_r.swt[B_SWT]; // see RL13
      end

      // Status pin
      case (s_r.pin[B_PSEL +: 2])
         PSEL_FG:  s_nxt.spin = s_r.foreground_complete_flag; // see RL12
         PSEL_STP: s_nxt.spin = s_r.stopped;
         PSEL_ALM: s_nxt.spin = s_r.alm_q;
         default:  s_nxt.spin = 1'b0;
      endcase

      // ==========================================================================
      // Sequencer; config is read live, so software must hold it idle to change it
      if (s_r.cnt != 12'h000) begin
         s_nxt.cnt = s_r.cnt - 12'h001;
      end
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.foreground_complete_flag = 1'b0;
            s_nxt.stopped = 1'b0;
            s_nxt.bg_os   = 1'b0;
            if (s_r.run[B_RUN]) begin
               s_nxt.vrst = 1'b1; // see RL4
               if (!s_r.mode[B_FGSEL]) begin
                  s_nxt.foreground_complete_flag = 1'b1; // see RL4
                  s_nxt.st = s_r.mode[B_BGEN] ? ST_BG_RUN : ST_DONE;
                  s_nxt.stopped = ~s_r.mode[B_BGEN]; // see RL10
                  s_nxt.cnt = phase_len(LIN_BASE, s_r.avg[B_LAVG +: 3]);
               end else if (s_r.mode[B_FGOS]) begin
                  s_nxt.st  = ST_FG_OS; // see RL2
                  s_nxt.cnt = phase_len(OS_BASE, s_r.avg[B_OAVG +: 3]); // see RL7
               end else begin
                  s_nxt.st  = ST_FG_LIN;
                  s_nxt.cnt = phase_len(LIN_BASE, s_r.avg[B_LAVG +: 3]); // see RL8
               end
            end
         end
         ST_FG_OS: begin
            if (s_r.cnt == 12'h000) begin
               s_nxt.st  = ST_FG_LIN;
               s_nxt.cnt = phase_len(LIN_BASE, s_r.avg[B_LAVG +: 3]); // see RL8
            end
         end
         ST_FG_LIN: begin
            if (s_r.cnt == 12'h000) begin
               s_nxt.foreground_complete_flag = 1'b1; // see RL11
               s_nxt.cnt = phase_len(LIN_BASE, s_r.avg[B_LAVG +: 3]);
               if (s_r.mode[B_BGEN]) begin
                  s_nxt.st = ST_BG_RUN; // see RL3
               end else begin
                  s_nxt.st = ST_DONE;
                  s_nxt.stopped = 1'b1; // see RL10
               end
            end
         end
         ST_BG_RUN: begin
            // A low trigger asks to halt; honoured only at a phase boundary
            if (!s_r.mode[B_BGEN]) begin
               s_nxt.st = ST_DONE; // see RL3
               s_nxt.bg_os = 1'b0;
               s_nxt.stopped = 1'b1;
            end else if (s_r.cnt == 12'h000) begin
               if (!s_r.trig) begin
                  s_nxt.st = ST_BG_STP;
                  s_nxt.stopped = 1'b1; // see RL9
               end else if (!s_r.bg_os && s_r.mode[B_BGOS]) begin
                  s_nxt.bg_os = 1'b1; // see RL1
                  s_nxt.cnt = phase_len(OS_BASE, s_r.avg[B_OAVG +: 3]); // see RL7
               end else begin
                  s_nxt.bg_os = 1'b0;
                  s_nxt.cnt = phase_len(LIN_BASE, s_r.avg[B_LAVG +: 3]);
               end
            end
         end
         ST_BG_STP: begin
            s_nxt.bg_os = 1'b0;
            if (!s_r.mode[B_BGEN]) begin
               s_nxt.st = ST_DONE;
            end else if (s_r.trig) begin
               s_nxt.st = ST_BG_RUN;
               s_nxt.stopped = 1'b0; // see RL9
               s_nxt.cnt = phase_len(LIN_BASE, s_r.avg[B_LAVG +: 3]);
            end
         end
         ST_DONE: begin
            if (s_r.mode[B_BGEN]) begin
               s_nxt.st = ST_BG_RUN;
               s_nxt.stopped = 1'b0;
               s_nxt.cnt = phase_len(LIN_BASE, s_r.avg[B_LAVG +: 3]);
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
      // Clearing the run bit holds everything idle at once
      if (!s_r.run[B_RUN]) begin
         s_nxt.st = ST_IDLE; // see RL16
         s_nxt.cnt = 12'h000;
         // Flags drop with the run bit, so a status read right after it is clean
         s_nxt.foreground_complete_flag = 1'b0;
         s_nxt.stopped = 1'b0;
         s_nxt.bg_os   = 1'b0;
      end

      // Interrupt flags: write one to clear, a new event wins
      if (wr_go && idx == IDX_IRQS) begin
         s_nxt.irqs = s_r.irqs & ~avs_writedata[1:0];
      end
      fg_rise  = s_nxt.foreground_complete_flag & ~s_r.foreground_complete_flag;
      stp_rise = s_nxt.stopped & ~s_r.stopped;
      if (fg_rise) begin
         s_nxt.irqs[IRQ_FG] = 1'b1;
      end
      if (stp_rise) begin
         s_nxt.irqs[IRQ_STP] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r       <= '0;
         s_r.run   <= RST_RUN;
         s_r.mode  <= RST_MODE; // see RL3 see RL4
         s_r.oref  <= RST_OREF;
         s_r.avg   <= RST_AVG;  // see RL7 see RL8
         s_r.pin   <= RST_PIN;
         s_r.swt   <= RST_SWT;  // see RL17
         s_r.irqs  <= RST_IRQ;
         s_r.irqm  <= RST_IRQ;
         s_r.st    <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================================
   // Outputs
   assign avs_readdata      = s_r.rdata;
   assign avs_waitrequest   = (avs_read | avs_write) & ~s_r.ack;
   assign status_output_pin = s_r.spin;
   assign irq               = |(s_r.irqs & s_r.irqm);
   assign cal_trigger       = s_r.trig;
   assign cal_values_reset  = s_r.vrst;
   assign fg_offset_active  = (s_r.st == ST_FG_OS);
   assign lin_cal_active    = (s_r.st == ST_FG_LIN) | ((s_r.st == ST_BG_RUN) & ~s_r.bg_os);
   assign bg_offset_active  = s_r.bg_os & (s_r.st == ST_BG_RUN);
   // Spare reference only valid with background on; otherwise fall back to mid-code
   assign offset_ref_spare  = s_r.oref[B_OREF] & s_r.mode[B_BGEN]; // see RL5 see RL6
   assign offset_averaging_depth    = s_r.avg[B_OAVG +: 3];
   assign linearity_averaging_depth = s_r.avg[B_LAVG +: 3];

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   bgos_gate_a: assert property (bg_offset_active |-> s_r.mode[B_BGOS] && s_r.mode[B_BGEN]) // see RL1
      else $error("background offset phase without its enables");
   fgos_gate_a: assert property ((s_r.st == ST_IDLE && s_r.run[B_RUN] && s_r.mode[B_FGSEL]) |=> // see RL2
                                 (fg_offset_active == $past(s_r.mode[B_FGOS])))
      else $error("foreground offset phase choice wrong");
   bg_reset_a: assert property ($fell(srst) |-> s_r.mode == RST_MODE && s_r.swt == RST_SWT) // see RL3
      else $error("mode or trigger reset value wrong");
   skip_fg_a: assert property ((s_r.st == ST_IDLE && s_r.run[B_RUN] && !s_r.mode[B_FGSEL]) |=> // see RL4
                               s_r.foreground_complete_flag && cal_values_reset && !fg_offset_active)
      else $error("skipped foreground not flagged");
   os_len_a: assert property ($rose(fg_offset_active) && s_r.avg[B_OAVG +: 3] == 3'h0 // see RL7
                              |-> fg_offset_active [*8] ##1 !fg_offset_active)
      else $error("offset phase length wrong");
   resume_a: assert property ((s_r.st == ST_BG_STP && s_r.trig && s_r.mode[B_BGEN]) |=> !s_r.stopped) // see RL9
      else $error("stopped flag not cleared on resume");
   done_nobg_a: assert property ($rose(s_r.foreground_complete_flag) && !s_r.mode[B_BGEN] |-> s_r.stopped) // see RL10
      else $error("stopped not set without background");
   pin_sel_a: assert property (s_r.pin[B_PSEL +: 2] == PSEL_STP && $stable(s_r.pin) |=> // see RL12
                               status_output_pin == $past(s_r.stopped))
      else $error("status pin does not follow stopped flag");
   soft_trig_a: assert property (!s_r.pin[B_TSRC] ##1 !s_r.pin[B_TSRC] |-> cal_trigger == $past(s_r.swt[B_SWT])) // see RL13
      else $error("software trigger not selected");
   hw_trig_a: assert property (s_r.pin[B_TSRC] ##1 s_r.pin[B_TSRC] |-> cal_trigger == $past(s_r.trg_q)) // see RL14
      else $error("hardware trigger not selected");
   ro_prog_a: assert property ((avs_write && !avs_waitrequest && idx == IDX_PROG) |=> // see RL18
                               s_r.run == $past(s_r.run) && s_r.mode == $past(s_r.mode))
      else $error("write to progress register changed state");
   wait_bound_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("bus answer late");

   halt_phase_a: assert property ((s_r.st == ST_BG_RUN && s_r.run[B_RUN] && s_r.mode[B_BGEN] && // see RL9
                                  s_r.cnt == 12'h000 && !s_r.trig) |=> s_r.stopped && s_r.st == ST_BG_STP)
      else $error("background did not halt at phase end");

   bg_off_a: assert property ((s_r.st == ST_BG_RUN && s_r.run[B_RUN] && !s_r.mode[B_BGEN]) |=> // see RL3
                              s_r.st == ST_DONE && s_r.stopped)
      else $error("background disable not honoured");

   done_flag_a: assert property ((s_r.st == ST_FG_LIN && s_r.run[B_RUN] && s_r.cnt == 12'h000) |=> s_r.foreground_complete_flag) // see RL11
      else $error("foreground complete flag not set");

   values_pulse_a: assert property (cal_values_reset |=> !cal_values_reset) // see RL4
      else $error("value reset pulse longer than one cycle");

   run_hold_a: assert property (!s_r.run[B_RUN] |=> s_r.st == ST_IDLE && !s_r.foreground_complete_flag && !s_r.stopped) // see RL16
      else $error("cleared run bit did not hold idle");

   alarm_pin_a: assert property (s_r.pin[B_PSEL +: 2] == PSEL_ALM && $stable(s_r.pin) |=> // see RL12
                                 status_output_pin == $past(s_r.alm_q))
      else $error("status pin does not follow alarm");

   irq_fg_set_a: assert property ($rose(s_r.foreground_complete_flag) |-> s_r.irqs[IRQ_FG])
      else $error("complete event did not set its status bit");

   irq_stop_set_a: assert property ($rose(s_r.stopped) |-> s_r.irqs[IRQ_STP])
      else $error("stopped event did not set its status bit");

   fg_full_c: cover property ($rose(s_r.foreground_complete_flag) && s_r.mode[B_FGOS]);
   bg_stop_c: cover property ($rose(s_r.stopped) && s_r.mode[B_BGEN]);
   bg_os_c: cover property ($rose(bg_offset_active));
   irq_c: cover property ($rose(irq));
endmodule

/* File: tb/adccal_pin_drv.sv */
// Far-side pin logic: drives the trigger and alarm pins of the calibration block
`timescale 1ns/100ps
module adccal_pin_drv (
   input  wire logic ref_clk,              // Bench clock
   input  wire logic trig_lvl,             // Requested trigger level
   input  wire logic alarm_lvl,            // Requested alarm level
   output logic      hardware_trigger_pin, // Trigger pin to the device
   output logic      alarm_pin             // Alarm summary to the device
);
   // Both lines are always driven, so there is no released state to model
   initial begin
      hardware_trigger_pin = 1'b1;
      alarm_pin = 1'b0;
   end
   always @(posedge ref_clk) begin
      hardware_trigger_pin <= trig_lvl;
      alarm_pin            <= alarm_lvl;
   end
endmodule

/* File: tb/adccal_regs_test.sv */
// Self-checking bench for the calibration control register block
`timescale 1ns/100ps
module adccal_regs_test;
   import adccal_pkg::*;
   logic        ref_clk;
   logic        srst;
   logic [9:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        hw_pin;
   logic        alarm_pin;
   logic        stat_pin;
   logic        irq;
   logic        cal_trigger;
   logic        clr_p;
   logic        fgos_a;
   logic        lin_a;
   logic        bgos_a;
   logic        spare;
   logic [2:0]  oavg;
   logic [2:0]  lavg;
   logic        trig_lvl;
   logic        alarm_lvl;
   logic [31:0] rd;
   logic [7:0]  mdl [int];
   logic [7:0]  fm [4];
   logic [7:0]  fa [4];
   int          fo [4];
   int          fl [4];
   int          num_errors;
   int          n_compared;
   int          fgos_n, bgos_n, lin_n, clr_n;
   int          f0, l0, c0;
   logic        p, s, e;

   adccal_regs #(.LIN_BASE(2), .OS_BASE(8)) dut_u (
      .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .hardware_trigger_pin(hw_pin), .alarm_pin(alarm_pin), .status_output_pin(stat_pin),
      .irq(irq), .cal_trigger(cal_trigger), .cal_values_reset(clr_p), .fg_offset_active(fgos_a),
      .lin_cal_active(lin_a), .bg_offset_active(bgos_a), .offset_ref_spare(spare),
      .offset_averaging_depth(oavg), .linearity_averaging_depth(lavg));

   adccal_pin_drv far_u (.ref_clk(ref_clk), .trig_lvl(trig_lvl), .alarm_lvl(alarm_lvl),
      .hardware_trigger_pin(hw_pin), .alarm_pin(alarm_pin));

   // ==========================================================================
   // Clock, activity counters, watchdog
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (fgos_a === 1'b1) fgos_n++;
      if (bgos_a === 1'b1) bgos_n++;
      if (lin_a === 1'b1) lin_n++;
      if (clr_p === 1'b1) clr_n++;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      num_errors++;
      finish_test();
   end

   // ==========================================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Entered just after an edge; holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      avs_address   <= {idx, 2'b00};
      avs_read      <= ~wr;
      avs_write     <= wr;
      avs_writedata <= {24'h0, wd};
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      if (n >= 64) num_errors++;
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
      if (mdl.exists(idx)) mdl[idx] = d;
   endtask

   task automatic rde(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
   endtask

   task automatic rdc(input logic [7:0] idx);
      rde(idx, mdl.exists(idx) ? mdl[idx] : 8'h00);
   endtask

   task automatic poll(input int b, input logic [2:0] v, input int w);
      int n;
      n = 0;
      do begin
         bus(1'b0, IDX_PROG, 8'h00);
         n++;
      end while (((rd >> b) & ((1 << w) - 1)) !== {29'h0, v} && n < 200);
      if (n >= 200) num_errors++;
   endtask

   // Settings change only with the run bit cleared; reserved bits keep defaults
   task automatic cfg(input logic [7:0] mode, input logic [7:0] oref, input logic [7:0] avg);
      wr(IDX_RUN, 8'h00);
      wr(IDX_MODE, mode);
      wr(IDX_OREF, oref);
      wr(IDX_AVG, avg);
      wr(IDX_RUN, 8'h01);
   endtask

   task automatic finish_test();
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      srst = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hf;
      trig_lvl = 1'b1;
      alarm_lvl = 1'b0;
      num_errors = 0;
      n_compared = 0;
      fgos_n = 0; bgos_n = 0; lin_n = 0; clr_n = 0;
      mdl[IDX_RUN] = RST_RUN; mdl[IDX_MODE] = RST_MODE; mdl[IDX_OREF] = RST_OREF;
      mdl[IDX_AVG] = RST_AVG; mdl[IDX_PIN] = RST_PIN; mdl[IDX_SWT] = RST_SWT; mdl[IDX_IRQM] = 8'h00;
      fm = '{8'h00, 8'h05, 8'h05, 8'h01};
      fa = '{8'h00, 8'h00, 8'h22, 8'h00};
      void'($urandom(57055));
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      chk(oavg, 3'h6);
      chk(lavg, 3'h1);
      foreach (mdl[i]) rdc(i[7:0]);
      wr(8'h63, 8'hff);
      rdc(8'h63);
      wr(IDX_RUN, 8'h00);
      rde(IDX_PROG, 8'h00);
      bus(1'b1, IDX_PROG, 8'hff);
      rde(IDX_PROG, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(IDX_AVG, 8'($urandom) & 8'h77);
         chk({oavg, lavg}, {mdl[IDX_AVG][6:4], mdl[IDX_AVG][2:0]});
      end
      // Foreground runs: skip, with and without offset, two averaging depths
      for (int i = 0; i < 4; i++) begin
         f0 = fgos_n; l0 = lin_n; c0 = clr_n;
         cfg(fm[i], 8'h01, fa[i]);
         poll(0, 3'h1, 1);
         rde(IDX_PROG, 8'h17);
         chk(clr_n - c0, 1);
         fo[i] = fgos_n - f0;
         fl[i] = lin_n - l0;
         chk(fo[i] > 0, fm[i][2]);
         chk(fl[i] > 0, fm[i][0]);
      end
      chk(fo[2] > fo[1], 1);
      chk(fl[2] > fl[1], 1);
      chk(irq, 1'b0);
      rde(IDX_IRQS, 8'h03);
      wr(IDX_IRQM, 8'h01);
      chk(irq, 1'b1);
      bus(1'b1, IDX_IRQS, 8'h01);
      chk(irq, 1'b0);
      rde(IDX_IRQS, 8'h02);
      // Background with offset phases and the spare reference
      b0: begin
         cfg(8'h0b, 8'h05, 8'h00);
         poll(2, 3'h3, 3);
         f0 = bgos_n;
         repeat (60) @(posedge ref_clk);
         chk(bgos_n > f0, 1);
         chk(spare, 1'b1);
      end
      for (int c = 0; c < 4; c++) begin
         alarm_lvl <= 1'($urandom);
         wr(IDX_PIN, 8'(c << 1));
         repeat (6) @(posedge ref_clk);
         e = (c == 0) ? 1'b1 : (c == 2) ? alarm_lvl : 1'b0;
         chk(stat_pin, e);
      end
      wr(IDX_SWT, 8'h00);
      poll(1, 3'h1, 1);
      rde(IDX_PROG, 8'h13);
      wr(IDX_SWT, 8'h01);
      poll(1, 3'h0, 1);
      rde(IDX_PROG, 8'h0d);
      cfg(8'h03, 8'h01, 8'h00);
      poll(2, 3'h3, 3);
      f0 = bgos_n;
      repeat (60) @(posedge ref_clk);
      chk(bgos_n - f0, 0);
      chk(spare, 1'b0);
      // Trigger source select with random pin and software levels
      wr(IDX_RUN, 8'h00);
      for (int i = 0; i < 6; i++) begin
         p = 1'($urandom);
         s = 1'($urandom);
         trig_lvl <= p;
         wr(IDX_SWT, {7'h0, s});
         wr(IDX_PIN, {7'h0, i[0]});
         repeat (8) @(posedge ref_clk);
         chk(cal_trigger, i[0] ? p : s);
      end
      finish_test();
   end
endmodule
